// ---- design/rls_rx_status.sv ----
`timescale 1ns/1ps
`include "rls_map.svh"

// What this block does
// - Multi-use output holds bits 31:24 of the latest control word with a good CRC24.
// - Lane synchronized needs word lock, good metaframe sync and scrambler word.
// - All status outputs are registered on the local bus clock.
// - Lane sync error set on a framing error while hunting or locked.
// - Metaframe length error set when a metaframe has the wrong length.
// - Consecutive metaframe error set on back-to-back metaframe errors.
// - Scrambler state error set when received state differs from expected.
// - Aligned output high only while every active lane is aligned.
// - Received data is accepted and delivered only while aligned.
// - Alignment error only on loss of alignment once it was reached.
// - Control word CRC error on CRC24 mismatch.
// - Overflow flag when the local bus drains too slowly.
// - Flow-control status cleared on CRC24 error or alignment loss.
// - Multi-use updated pulses one cycle per new multi-use value.
// - Word lock after 64 consecutive valid framing patterns in bits 65:64.

module rls_rx_status
    import rls_pkg::*;
#(
    parameter int LANES = rls_pkg::RLS_LANES,
    parameter int FC_W  = rls_pkg::RLS_FC_W
) (
    // Clock and reset
    input  wire logic                 pclk,
    input  wire logic                 presetn,
    // APB slave
    input  wire logic                 psel,
    input  wire logic                 penable,
    input  wire logic                 pwrite,
    input  wire logic [11:0]          paddr,
    input  wire logic [31:0]          pwdata,
    output logic                      pready,
    output logic [31:0]               prdata,
    output logic                      pslverr,
    // Lane events from the decoder
    input  wire logic [LANES-1:0]     lane_word_vld,
    input  wire logic [2*LANES-1:0]   lane_frm_bits,
    input  wire logic [LANES-1:0]     lane_mf_sync_ok,
    input  wire logic [LANES-1:0]     lane_scr_word_ok,
    input  wire logic [LANES-1:0]     lane_mf_len_bad,
    input  wire logic [LANES-1:0]     lane_mf_bad,
    input  wire logic [LANES-1:0]     lane_scr_mismatch,
    input  wire logic [LANES-1:0]     lane_deskewed,
    // Control word events
    input  wire logic                 cw_vld,
    input  wire logic [31:0]          cw_low,
    input  wire logic                 cw_crc_bad,
    input  wire logic                 fc_vld,
    input  wire logic [FC_W-1:0]      fc_bits,
    input  wire logic                 fifo_wr_full,
    // Received data path
    input  wire logic                 rx_data_vld,
    input  wire logic [63:0]          rx_data,
    // External resync
    input  wire logic                 force_resync,
    // Status outputs
    output logic [7:0]                rx_multiuse_bits,
    output logic                      multiuse_bits_updated,
    output logic [LANES-1:0]          lane_word_synchronized,
    output logic [LANES-1:0]          lane_sync_error,
    output logic [LANES-1:0]          metaframe_length_error,
    output logic [LANES-1:0]          metaframe_consecutive_error,
    output logic [LANES-1:0]          scrambler_state_error,
    output logic                      rx_aligned,
    output logic                      rx_aligned_error,
    output logic                      control_word_crc_error,
    output logic                      rx_overflow_error,
    output logic [FC_W-1:0]           rx_flow_control_status,
    output logic                      rx_out_vld,
    output logic [63:0]               rx_out_data,
    output logic                      irq
);
    typedef struct packed {
        logic [1:0]           ctrl;
        logic [LANES-1:0]     lane_en;
        logic [5:0]           irq_stat;
        logic [5:0]           irq_mask;
        logic [7:0]           mu;
        logic                 mu_upd;
        logic [LANES-1:0]     synced;
        logic [LANES-1:0]     sync_err;
        logic [LANES-1:0]     len_err;
        logic [LANES-1:0]     rep_err;
        logic [LANES-1:0]     prev_mf_bad;
        logic [LANES-1:0]     scr_err;
        logic                 aligned;
        logic                 ever_aligned;
        logic                 align_err;
        logic                 crc_err;
        logic                 ovfl;
        logic [FC_W-1:0]      fc;
        logic                 out_vld;
        logic [63:0]          out_data;
        logic                 pready;
        logic [31:0]          prdata;
        logic                 pslverr;
        logic                 irq;
    } rls_state_t;

    rls_state_t       s_r;
    rls_state_t       s_nxt;
    logic [LANES-1:0] locked;
    logic [LANES-1:0] lock_err;
    logic             clr;

    // ==========================================================
    // Per-lane word lock
    assign clr = force_resync | s_r.ctrl[`RLS_CTRL_RESYNC] | s_r.ctrl[`RLS_CTRL_HOLD];

    for (genvar i = 0; i < LANES; i++) begin : g_lane
        rls_lane_lock u_lock (
            .pclk     (pclk),
            .presetn  (presetn),
            .clr      (clr),
            .word_vld (lane_word_vld[i]),
            .frm_bits (lane_frm_bits[2*i+1 -: 2]),
            .locked   (locked[i]),
            .lock_err (lock_err[i])
        );
    end

    // ==========================================================
    // Next state
    always_comb begin
        logic             setup;
        logic             acc;
        logic             all_ok;
        logic [5:0]       ev;
        logic [LANES-1:0] mask_en;
        setup   = psel && !penable;
        acc     = psel && penable;
        all_ok  = 1'b0;
        s_nxt   = s_r;
        ev      = '0;
        mask_en = s_r.lane_en;

        // Resync request is self-clearing
        s_nxt.ctrl[`RLS_CTRL_RESYNC] = 1'b0;
        s_nxt.mu_upd  = 1'b0;
        s_nxt.out_vld = 1'b0;

        if (clr) begin
            s_nxt.synced       = '0;
            s_nxt.sync_err     = '0;
            s_nxt.len_err      = '0;
            s_nxt.rep_err      = '0;
            s_nxt.prev_mf_bad  = '0;
            s_nxt.scr_err      = '0;
            s_nxt.aligned      = 1'b0;
            s_nxt.ever_aligned = 1'b0;
            s_nxt.align_err    = 1'b0;
            s_nxt.crc_err      = 1'b0;
            s_nxt.ovfl         = 1'b0;
            s_nxt.fc           = '0;
        end else begin
            s_nxt.synced   = locked & lane_mf_sync_ok & lane_scr_word_ok;
            s_nxt.sync_err = lock_err;
            s_nxt.len_err  = lane_mf_len_bad;
            s_nxt.rep_err  = lane_mf_bad & s_r.prev_mf_bad;
            for (int i = 0; i < LANES; i++) begin
                if (lane_mf_bad[i] || lane_mf_len_bad[i]) begin
                    s_nxt.prev_mf_bad[i] = lane_mf_bad[i];
                end
            end
            s_nxt.scr_err  = lane_scr_mismatch;
            all_ok = (mask_en != '0) &&
                     ((s_r.synced & lane_deskewed & mask_en) == mask_en);
            s_nxt.aligned   = all_ok;
            if (all_ok) begin
                s_nxt.ever_aligned = 1'b1;
            end
            // Misalignment is reported only once alignment was reached
            s_nxt.align_err = s_r.ever_aligned && s_r.aligned && !all_ok;
            s_nxt.crc_err   = cw_vld && cw_crc_bad;
            s_nxt.ovfl      = rx_data_vld && fifo_wr_full;
            if (cw_vld && !cw_crc_bad) begin
                s_nxt.mu     = cw_low[`RLS_MU_HI:`RLS_MU_LO];
                s_nxt.mu_upd = 1'b1;
                if (fc_vld) begin
                    s_nxt.fc = fc_bits;
                end
            end
            if (s_nxt.crc_err || s_nxt.align_err) begin
                s_nxt.fc = '0;
            end
            if (s_r.aligned && rx_data_vld && !fifo_wr_full) begin
                s_nxt.out_vld  = 1'b1;
                s_nxt.out_data = rx_data;
            end
        end

        // ======================================================
        // Interrupt events, set wins over clear
        ev[`RLS_IRQ_ALIGN_ERR] = s_nxt.align_err;
        ev[`RLS_IRQ_CRC_ERR]   = s_nxt.crc_err;
        ev[`RLS_IRQ_OVFL]      = s_nxt.ovfl;
        ev[`RLS_IRQ_LANE_ERR]  = |{s_nxt.sync_err, s_nxt.len_err,
                                   s_nxt.rep_err, s_nxt.scr_err};
        ev[`RLS_IRQ_MU_UPD]    = s_nxt.mu_upd;
        ev[`RLS_IRQ_ALIGNED]   = s_nxt.aligned && !s_r.aligned;

        // ======================================================
        // APB: one wait-free access phase
        s_nxt.pready  = setup;
        s_nxt.pslverr = 1'b0;
        if (setup && !pwrite) begin
            s_nxt.prdata = '0;
            unique case (paddr)
                `RLS_OFF_CTRL:      s_nxt.prdata[1:0] = s_r.ctrl;
                `RLS_OFF_LANE_EN:   s_nxt.prdata[LANES-1:0] = s_r.lane_en;
                `RLS_OFF_SYNCED:    s_nxt.prdata[LANES-1:0] = s_r.synced;
                `RLS_OFF_WORD_LOCK: s_nxt.prdata[LANES-1:0] = locked;
                `RLS_OFF_MULTIUSE:  s_nxt.prdata[7:0] = s_r.mu;
                `RLS_OFF_IRQ_STAT:  s_nxt.prdata[5:0] = s_r.irq_stat;
                `RLS_OFF_IRQ_MASK:  s_nxt.prdata[5:0] = s_r.irq_mask;
                `RLS_OFF_LSYNC_ERR: s_nxt.prdata[LANES-1:0] = s_r.sync_err;
                `RLS_OFF_MFLEN_ERR: s_nxt.prdata[LANES-1:0] = s_r.len_err;
                `RLS_OFF_MFREP_ERR: s_nxt.prdata[LANES-1:0] = s_r.rep_err;
                `RLS_OFF_SCR_ERR:   s_nxt.prdata[LANES-1:0] = s_r.scr_err;
                `RLS_OFF_FC_LO:     s_nxt.prdata = s_r.fc[31:0];
                default:            s_nxt.pslverr = 1'b1;
            endcase
        end else if (setup) begin
            unique case (paddr)
                `RLS_OFF_CTRL, `RLS_OFF_LANE_EN, `RLS_OFF_IRQ_STAT,
                `RLS_OFF_IRQ_MASK: s_nxt.pslverr = 1'b0;
                default:           s_nxt.pslverr = 1'b1;
            endcase
        end

        s_nxt.irq_stat = s_r.irq_stat;
        if (acc && pwrite && s_r.pready) begin
            unique case (paddr)
                `RLS_OFF_CTRL:     s_nxt.ctrl = pwdata[1:0];
                `RLS_OFF_LANE_EN:  s_nxt.lane_en = pwdata[LANES-1:0];
                `RLS_OFF_IRQ_STAT: s_nxt.irq_stat = s_r.irq_stat & ~pwdata[5:0];
                `RLS_OFF_IRQ_MASK: s_nxt.irq_mask = pwdata[5:0];
                default:           s_nxt.ctrl = s_nxt.ctrl;
            endcase
        end
        s_nxt.irq_stat = s_nxt.irq_stat | ev;
        s_nxt.irq      = |(s_nxt.irq_stat & s_nxt.irq_mask);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_r          <= '0;
            s_r.lane_en  <= `RLS_LANE_EN_RST;
            s_r.irq_mask <= `RLS_IRQ_MASK_RST;
        end else begin
            s_r <= s_nxt;
        end
    end

    // ==========================================================
    // Outputs, all from flip-flops
    assign pready                      = s_r.pready;
    assign prdata                      = s_r.prdata;
    assign pslverr                     = s_r.pslverr;
    assign rx_multiuse_bits            = s_r.mu;
    assign multiuse_bits_updated       = s_r.mu_upd;
    assign lane_word_synchronized      = s_r.synced;
    assign lane_sync_error             = s_r.sync_err;
    assign metaframe_length_error      = s_r.len_err;
    assign metaframe_consecutive_error = s_r.rep_err;
    assign scrambler_state_error       = s_r.scr_err;
    assign rx_aligned                  = s_r.aligned;
    assign rx_aligned_error            = s_r.align_err;
    assign control_word_crc_error      = s_r.crc_err;
    assign rx_overflow_error           = s_r.ovfl;
    assign rx_flow_control_status      = s_r.fc;
    assign rx_out_vld                  = s_r.out_vld;
    assign rx_out_data                 = s_r.out_data;
    assign irq                         = s_r.irq;
endmodule

// ---- design/rls_map.svh ----
`ifndef RLS_MAP_SVH
`define RLS_MAP_SVH

// APB register offsets (byte addresses)
`define RLS_OFF_CTRL      12'h000
`define RLS_OFF_LANE_EN   12'h004
`define RLS_OFF_SYNCED    12'h008
`define RLS_OFF_WORD_LOCK 12'h00C
`define RLS_OFF_MULTIUSE  12'h010
`define RLS_OFF_IRQ_STAT  12'h014
`define RLS_OFF_IRQ_MASK  12'h018
`define RLS_OFF_LSYNC_ERR 12'h01C
`define RLS_OFF_MFLEN_ERR 12'h020
`define RLS_OFF_MFREP_ERR 12'h024
`define RLS_OFF_SCR_ERR   12'h028
`define RLS_OFF_FC_LO     12'h02C

// Control register fields
`define RLS_CTRL_RESYNC   0
`define RLS_CTRL_HOLD     1

// Interrupt status bit positions
`define RLS_IRQ_ALIGN_ERR 0
`define RLS_IRQ_CRC_ERR   1
`define RLS_IRQ_OVFL      2
`define RLS_IRQ_LANE_ERR  3
`define RLS_IRQ_MU_UPD    4
`define RLS_IRQ_ALIGNED   5
`define RLS_IRQ_W         6

// Reset values
`define RLS_LANE_EN_RST   12'hFFF
`define RLS_IRQ_MASK_RST  6'h00

// Field positions in the received words
`define RLS_MU_HI         31
`define RLS_MU_LO         24
`define RLS_FRM_HI        65
`define RLS_FRM_LO        64
`define RLS_FRM_GOOD_A    2'b01
`define RLS_FRM_GOOD_B    2'b10

// Word-lock count
`define RLS_LOCK_COUNT    7'd64

`endif

// ---- design/rls_pkg.sv ----
package rls_pkg;
    localparam int RLS_LANES = 12;
    localparam int RLS_FC_W  = 256;

    typedef enum logic [2:0] {
        RLS_HUNT   = 3'b001,
        RLS_LOCKED = 3'b010,
        RLS_SLIP   = 3'b100
    } rls_lock_st_t;
endpackage

// ---- design/rls_lane_lock.sv ----
`timescale 1ns/1ps
`include "rls_map.svh"

module rls_lane_lock
    import rls_pkg::*;
(
    // Clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        clr,
    // Per-word framing
    input  wire logic        word_vld,
    input  wire logic [1:0]  frm_bits,
    // Status
    output logic             locked,
    output logic             lock_err
);
    typedef struct packed {
        rls_lock_st_t st;
        logic [6:0]   cnt;
        logic         err;
    } rls_ll_state_t;

    rls_ll_state_t s_r;
    rls_ll_state_t s_nxt;
    logic          good;

    always_comb begin
        good  = (frm_bits == `RLS_FRM_GOOD_A) || (frm_bits == `RLS_FRM_GOOD_B);
        s_nxt = s_r;
        s_nxt.err = 1'b0;
        if (clr) begin
            s_nxt.st  = RLS_HUNT;
            s_nxt.cnt = '0;
        end else if (word_vld) begin
            unique case (s_r.st)
                RLS_HUNT: begin
                    if (!good) begin
                        s_nxt.cnt = '0;
                        s_nxt.err = 1'b1;
                    end else if (s_r.cnt == `RLS_LOCK_COUNT - 7'd1) begin
                        s_nxt.st  = RLS_LOCKED;
                        s_nxt.cnt = '0;
                    end else begin
                        s_nxt.cnt = s_r.cnt + 7'd1;
                    end
                end
                RLS_LOCKED: begin
                    if (!good) begin
                        s_nxt.st  = RLS_SLIP;
                        s_nxt.err = 1'b1;
                    end
                end
                RLS_SLIP: begin
                    // A lost lock must be regained from scratch
                    s_nxt.st  = RLS_HUNT;
                    s_nxt.cnt = '0;
                end
                default: begin
                    s_nxt.st  = RLS_HUNT;
                    s_nxt.cnt = '0;
                end
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_r <= '{st: RLS_HUNT, cnt: 7'd0, err: 1'b0};
        end else begin
            s_r <= s_nxt;
        end
    end

    assign locked   = (s_r.st == RLS_LOCKED);
    assign lock_err = s_r.err;
endmodule

// ---- testbench/rls_rx_status_chk.sv ----
`timescale 1ns/1ps
// ==========
// Port checker
module rls_rx_status_chk
    import rls_pkg::*;
#(
    parameter int LANES = RLS_LANES,
    parameter int FC_W  = RLS_FC_W
) (
    // Clock and reset
    input wire logic             pclk,
    input wire logic             presetn,
    // Lane events
    input wire logic [LANES-1:0] lane_word_vld,
    input wire logic [LANES-1:0] lane_mf_sync_ok,
    input wire logic [LANES-1:0] lane_scr_word_ok,
    input wire logic [LANES-1:0] lane_mf_len_bad,
    input wire logic [LANES-1:0] lane_mf_bad,
    input wire logic [LANES-1:0] lane_scr_mismatch,
    input wire logic [LANES-1:0] lane_deskewed,
    // Control word and data
    input wire logic             cw_vld,
    input wire logic [31:0]      cw_low,
    input wire logic             cw_crc_bad,
    input wire logic             fifo_wr_full,
    input wire logic             rx_data_vld,
    input wire logic [63:0]      rx_data,
    input wire logic             force_resync,
    // Status
    input wire logic [7:0]       rx_multiuse_bits,
    input wire logic             multiuse_bits_updated,
    input wire logic [LANES-1:0] lane_word_synchronized,
    input wire logic [LANES-1:0] lane_sync_error,
    input wire logic [LANES-1:0] metaframe_length_error,
    input wire logic [LANES-1:0] metaframe_consecutive_error,
    input wire logic [LANES-1:0] scrambler_state_error,
    input wire logic             rx_aligned,
    input wire logic             rx_aligned_error,
    input wire logic             control_word_crc_error,
    input wire logic             rx_overflow_error,
    input wire logic [FC_W-1:0]  rx_flow_control_status,
    input wire logic             rx_out_vld,
    input wire logic [63:0]      rx_out_data
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    AST_MU_NEW: assert property (cw_vld && !cw_crc_bad && !force_resync |=>
        multiuse_bits_updated && rx_multiuse_bits == $past(cw_low[31:24])) else $error("mu bad");
    AST_UPD_CAUSE: assert property (multiuse_bits_updated |->
        $past(cw_vld && !cw_crc_bad)) else $error("stray mu update");
    AST_CRC: assert property (cw_vld && cw_crc_bad && !force_resync |=>
        control_word_crc_error && rx_flow_control_status == '0) else $error("crc flag");
    AST_SYNC: assert property ((lane_word_synchronized &
        ~$past(lane_mf_sync_ok & lane_scr_word_ok)) == '0) else $error("synced early");
    AST_ALIGN: assert property (rx_aligned |->
        $past(lane_word_synchronized & lane_deskewed) != '0) else $error("aligned early");
    AST_DATA: assert property (rx_out_vld |-> $past(rx_data_vld && rx_aligned &&
        !fifo_wr_full) && rx_out_data == $past(rx_data)) else $error("data gate");
    AST_OVFL: assert property (rx_data_vld && fifo_wr_full && !force_resync |=>
        rx_overflow_error) else $error("no overflow");
    AST_ALERR: assert property (rx_aligned_error |->
        !rx_aligned && rx_flow_control_status == '0) else $error("align err");
    AST_LOSS: assert property ($fell(rx_aligned) && !force_resync && !$past(force_resync)
        |-> ##[0:1] rx_aligned_error) else $error("loss unflagged");
    AST_RESYNC: assert property (force_resync |=> !rx_aligned &&
        lane_word_synchronized == '0) else $error("resync held");
    AST_LEN: assert property (!force_resync |=>
        metaframe_length_error == $past(lane_mf_len_bad) &&
        scrambler_state_error == $past(lane_scr_mismatch)) else $error("lane err");
    AST_SYNCERR: assert property ((lane_sync_error & ~$past(lane_word_vld, 2)) == '0)
        else $error("sync err");
    AST_REP: assert property ((metaframe_consecutive_error & ~$past(lane_mf_bad)) == '0)
        else $error("repeat err");
    COV_MU: cover property (multiuse_bits_updated);
    COV_LOSS: cover property (rx_aligned_error);
    COV_REP: cover property (metaframe_consecutive_error != '0);
endmodule

bind rls_rx_status rls_rx_status_chk #(.LANES(LANES), .FC_W(FC_W)) rls_rx_status_chk_i (.*);

// ---- testbench/rls_far_tx.sv ----
`timescale 1ns/1ps
// ==========
// Far-end lane transmitter
module rls_far_tx (
    // Clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // Bench control
    input  wire logic        run,
    input  wire logic        slow,
    input  wire logic [11:0] bad,
    // Lane words
    output logic      [11:0] lane_word_vld,
    output logic      [23:0] lane_frm_bits
);
    logic tog_r;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tog_r <= 1'b0;
        end else begin
            tog_r <= ~tog_r;
        end
    end
    // Idle lines toggle so a stale value never looks valid
    always_comb begin
        lane_word_vld = {12{run & (~slow | tog_r)}};
        for (int i = 0; i < 12; i++) begin
            if (!lane_word_vld[i]) begin
                lane_frm_bits[2*i+:2] = {tog_r, tog_r};
            end else if (bad[i]) begin
                lane_frm_bits[2*i+:2] = 2'b11;
            end else begin
                lane_frm_bits[2*i+:2] = tog_r ? 2'b01 : 2'b10;
            end
        end
    end
endmodule

// ---- testbench/tb.sv ----
`timescale 1ns/1ps
`include "rls_map.svh"
// ==========
// Bench top
module tb;
    import rls_pkg::*;
    localparam int LANES = RLS_LANES;
    localparam int FC_W  = RLS_FC_W;
    typedef struct packed {
        logic [31:0] cw;
        logic        bad;
        logic [7:0]  mu;
    } rls_row_t;
    logic         pclk, presetn, psel, penable, pwrite, pready, pslverr, er, run, slow, se, ae;
    logic [11:0]  paddr, lane_word_vld, lane_mf_sync_ok, lane_scr_word_ok, lane_mf_len_bad;
    logic [11:0]  lane_mf_bad, lane_scr_mismatch, lane_deskewed, lane_word_synchronized, bad;
    logic [11:0]  lane_sync_error, metaframe_length_error, metaframe_consecutive_error;
    logic [11:0]  scrambler_state_error;
    logic [31:0]  pwdata, prdata, cw_low, rd;
    logic [23:0]  lane_frm_bits;
    logic         cw_vld, cw_crc_bad, fc_vld, fifo_wr_full, rx_data_vld, force_resync, irq;
    logic         multiuse_bits_updated, rx_aligned, rx_aligned_error, rx_out_vld;
    logic         control_word_crc_error, rx_overflow_error;
    logic [7:0]   rx_multiuse_bits;
    logic [63:0]  rx_data, rx_out_data;
    logic [255:0] fc_bits, rx_flow_control_status;
    int           errors, n_compared, n;
    rls_row_t     rows [5] = '{'{32'hAB00_0001, 1'b0, 8'hAB}, '{32'h5500_FFFF, 1'b0, 8'h55},
        '{32'h00FF_0000, 1'b1, 8'h55}, '{32'hFF00_0000, 1'b0, 8'hFF},
        '{32'h0000_0000, 1'b1, 8'hFF}};

    rls_rx_status #(.LANES(LANES), .FC_W(FC_W)) rls_rx_status_i (.*);
    rls_far_tx rls_far_tx_i (.*);

    initial begin
        pclk = 1'b0;
        forever #4 pclk = ~pclk;
    end
    // ==========
    // Tasks
    task chk(input logic [255:0] g, input logic [255:0] e);
        n_compared++;
        if (g !== e) begin
            errors++;
            $display("mismatch %0t got %0h exp %0h", $time, g, e);
        end
    endtask
    task final_report;
        if (errors == 0 && n_compared > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // No wait-state count assumed; the watchdog ends a hang
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task send_cw(input logic [31:0] w, input logic b);
        cw_vld <= 1'b1;
        cw_low <= w;
        cw_crc_bad <= b;
        fc_vld <= 1'b1;
        fc_bits <= {8{w}};
        @(posedge pclk);
        cw_vld <= 1'b0;
        fc_vld <= 1'b0;
        @(posedge pclk);
    endtask
    // ==========
    // Main sequence
    initial begin
        {psel, penable, pwrite, paddr, pwdata, run, slow, bad} = '0;
        {lane_mf_sync_ok, lane_scr_word_ok, lane_mf_len_bad, lane_mf_bad} = '0;
        {lane_scr_mismatch, lane_deskewed, cw_vld, cw_low, cw_crc_bad, fc_vld, fc_bits} = '0;
        {fifo_wr_full, rx_data_vld, rx_data, force_resync} = '0;
        errors = 0;
        n_compared = 0;
        presetn = 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        chk(lane_word_synchronized, 12'h000);
        apb(1'b0, `RLS_OFF_LANE_EN, 32'h0000_0000);
        chk(rd, 32'h0000_0FFF);
        apb(1'b0, `RLS_OFF_IRQ_MASK, 32'h0000_0000);
        chk(rd, 32'h0000_0000);
        apb(1'b0, 12'h100, 32'h0000_0000);
        chk(er, 1'b1);
        apb(1'b1, `RLS_OFF_SYNCED, 32'h0000_0001);
        chk(er, 1'b1);
        foreach (rows[i]) begin
            send_cw(rows[i].cw, rows[i].bad);
            chk(rx_multiuse_bits, rows[i].mu);
            chk(multiuse_bits_updated, !rows[i].bad);
            chk(control_word_crc_error, rows[i].bad);
            chk(rx_flow_control_status, rows[i].bad ? '0 : {8{rows[i].cw}});
        end
        lane_mf_len_bad <= 12'h020;
        lane_scr_mismatch <= 12'h080;
        lane_mf_bad <= 12'h008;
        @(posedge pclk);
        {lane_mf_len_bad, lane_scr_mismatch, lane_mf_bad} <= '0;
        @(posedge pclk);
        chk(metaframe_length_error, 12'h020);
        chk(scrambler_state_error, 12'h080);
        lane_mf_bad <= 12'h008;
        @(posedge pclk);
        lane_mf_bad <= 12'h000;
        @(posedge pclk);
        chk(metaframe_consecutive_error, 12'h008);
        {lane_mf_sync_ok, lane_scr_word_ok, lane_deskewed} <= '1;
        run <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (lane_word_synchronized !== 12'hFFF && n < 300);
        chk(n, 66);
        @(posedge pclk);
        chk(rx_aligned, 1'b1);
        rx_data_vld <= 1'b1;
        rx_data <= 64'h0123_4567_89AB_CDEF;
        @(posedge pclk);
        fifo_wr_full <= 1'b1;
        @(posedge pclk);
        chk(rx_out_data, 64'h0123_4567_89AB_CDEF);
        chk(rx_out_vld, 1'b1);
        {fifo_wr_full, rx_data_vld} <= '0;
        @(posedge pclk);
        chk(rx_overflow_error, 1'b1);
        chk(rx_out_vld, 1'b0);
        apb(1'b0, `RLS_OFF_IRQ_STAT, 32'h0000_0000);
        chk(rd, 32'h0000_003E);
        chk(irq, 1'b0);
        // A set mask bit lets its status bit through
        apb(1'b1, `RLS_OFF_IRQ_MASK, 32'h0000_003F);
        @(posedge pclk);
        chk(irq, 1'b1);
        apb(1'b1, `RLS_OFF_IRQ_STAT, 32'h0000_003F);
        apb(1'b0, `RLS_OFF_IRQ_STAT, 32'h0000_0000);
        chk(rd, 32'h0000_0000);
        chk(irq, 1'b0);
        apb(1'b1, `RLS_OFF_IRQ_MASK, 32'h0000_0000);
        send_cw(32'h1234_5678, 1'b0);
        bad <= 12'h001;
        {se, ae} = '0;
        repeat (10) begin
            @(posedge pclk);
            se = se | lane_sync_error[0];
            ae = ae | rx_aligned_error;
        end
        chk(se, 1'b1);
        chk(ae, 1'b1);
        chk(rx_aligned, 1'b0);
        chk(rx_flow_control_status, '0);
        bad <= 12'h000;
        slow <= 1'b1;
        force_resync <= 1'b1;
        repeat (2) @(posedge pclk);
        chk(lane_word_synchronized, 12'h000);
        force_resync <= 1'b0;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (lane_word_synchronized !== 12'hFFF && n < 400);
        chk(lane_word_synchronized, 12'hFFF);
        final_report();
    end

    initial begin
        #40000;
        errors++;
        final_report();
    end
endmodule
